// [core/asbc_ctrl.sv]
// host-side controller driving an asynchronous 16-bit static memory
// assumes one 100 MHz clock; the memory data pins are split in/out/oe
// Function
// RQ1 - selects off floats memory, standby
// RQ2 - read: selected lanes driven by memory
// RQ3 - write: selected lanes stored, others unchanged
// RQ4 - output drive high keeps pins floating
// RQ5 - write is overlap of all strobes
// RQ6 - time data against write-ending edge
// RQ7 - never drive bus while memory drives
// RQ8 - deselect with strobe high stays floating
// RQ9 - output drive high during write floats
// RQ10 - write strobe high through every read
// RQ11 - address valid before selects activate
// RQ12 - sample read data after address access
// RQ13 - output drive access time respected
// RQ14 - byte select access time respected
// RQ15 - address setup before write end
// RQ16 - byte selects early before write end
// RQ17 - write data setup before write end
// RQ18 - both byte selects high deselect
// RQ19 - intervals as rounded-up clock counts
`timescale 1ns/100ps
`include "asbc_regs.svh"
`default_nettype none
module asbc_ctrl
#(
  parameter bit SLOW_GRADE = 1'b0
)
(
  input  wire logic                    clk_i,
  input  wire logic                    rst_b_i,
  input  wire logic                    ce_i,
  input  wire logic                    req_valid_i,
  input  wire logic                    req_write_i,
  input  wire logic [`ASBC_ADDR_W-1:0] req_addr_i,
  input  wire logic [`ASBC_DATA_W-1:0] req_wdata_i,
  input  wire logic [1:0]              req_lanes_i,
  output logic                         req_ready_o,
  output logic                         rsp_valid_o,
  output logic [`ASBC_DATA_W-1:0]      rsp_rdata_o,
  output logic [`ASBC_ADDR_W-1:0]      mem_addr_o,
  output logic                         chip_select_n_o,
  output logic                         chip_select_hi_o,
  output logic                         write_n_o,
  output logic                         out_drive_n_o,
  output logic                         upper_byte_sel_n_o,
  output logic                         lower_byte_sel_n_o,
  input  wire logic [`ASBC_DATA_W-1:0] mem_data_i,
  output logic [`ASBC_DATA_W-1:0]      mem_data_o,
  output logic [`ASBC_DATA_W-1:0]      mem_data_oe_n_o
);
  import asbc_pkg::*;

  // cycle counts, rounded up [RQ19]
  localparam int RD_CYC  = SLOW_GRADE ? `ASBC_CYC(`ASBC_AA_SLOW_NS) : `ASBC_CYC(`ASBC_AA_FAST_NS);
  localparam int WR_NS_A = SLOW_GRADE ? `ASBC_AW_SLOW_NS : `ASBC_AW_FAST_NS;
  localparam int WR_NS_P = SLOW_GRADE ? `ASBC_PWE_SLOW_NS : `ASBC_PWE_FAST_NS;
  localparam int WR_NS_D = SLOW_GRADE ? `ASBC_SD_SLOW_NS : `ASBC_SD_FAST_NS;
  localparam int WR_NS   = (WR_NS_A > WR_NS_P) ? WR_NS_A : WR_NS_P;
  localparam int WR_CYC  = `ASBC_CYC(WR_NS);
  localparam int SD_CYC  = `ASBC_CYC(WR_NS_D);
  localparam int HZ_CYC  = SLOW_GRADE ? `ASBC_CYC(`ASBC_HZ_SLOW_NS) : `ASBC_CYC(`ASBC_HZ_FAST_NS);
  localparam logic [`ASBC_CNT_W-1:0] RD_CNT = `ASBC_CNT_W'(RD_CYC);
  localparam logic [`ASBC_CNT_W-1:0] WR_CNT = `ASBC_CNT_W'(WR_CYC);
  localparam logic [`ASBC_CNT_W-1:0] SD_CNT = `ASBC_CNT_W'(SD_CYC);
  localparam logic [`ASBC_CNT_W-1:0] HZ_CNT = `ASBC_CNT_W'(HZ_CYC);

  asbc_reg_t               r_q;
  asbc_reg_t               r_d;
  logic                    stable;
  logic [`ASBC_DATA_W-1:0] lane_mask;

  // read data: three flops, accept once stages two and three agree
  // only on selected lanes; unselected pins float and may wander
  assign lane_mask = {{(`ASBC_DATA_W/2){r_q.lanes[1]}}, {(`ASBC_DATA_W/2){r_q.lanes[0]}}};
  assign stable    = (((r_q.s2 ^ r_q.s3) & lane_mask) == '0);

  always_comb
  begin
    r_d      = r_q;
    r_d.done = 1'b0;
    r_d.s1   = mem_data_i;
    r_d.s2   = r_q.s1;
    r_d.s3   = r_q.s2;
    if (r_q.cnt != `ASBC_CNT_ZERO)
    begin
      r_d.cnt = r_q.cnt - `ASBC_CNT_ONE;
    end
    unique case (r_q.st)
      ST_IDLE:
      begin
        // selects off, both lanes off: memory floats [RQ1] [RQ18]
        r_d.cs      = 1'b0;
        r_d.we_n    = 1'b1;
        r_d.oe_n    = 1'b1;
        r_d.drive   = 1'b0;
        r_d.lanes_n = 2'b11;
        if (req_valid_i && (req_lanes_i != 2'b00))
        begin
          // address loaded here, selects rise next cycle [RQ11] [RQ15]
          r_d.addr  = req_addr_i;
          r_d.wdata = req_wdata_i;
          r_d.lanes = req_lanes_i;
          r_d.st    = req_write_i ? ST_WRITE : ST_READ;
          r_d.cnt   = req_write_i ? WR_CNT : RD_CNT + `ASBC_CNT_ONE;
        end
      end
      ST_READ:
      begin
        // strobe high for whole read [RQ10]; memory drives [RQ2] [RQ7]
        r_d.cs      = 1'b1;
        r_d.oe_n    = 1'b0;
        r_d.lanes_n = ~r_q.lanes;
        // sample after access times plus sync delay [RQ12] [RQ13] [RQ14]
        if (r_q.cnt == `ASBC_CNT_ZERO && stable)
        begin
          r_d.rdata = r_q.s3;
          r_d.done  = 1'b1;
          r_d.cs    = 1'b0;
          r_d.oe_n  = 1'b1;
          r_d.lanes_n = 2'b11;
          r_d.st    = ST_TURN;
          r_d.cnt   = HZ_CNT;
        end
      end
      ST_WRITE:
      begin
        // output drive stays high so memory floats [RQ4] [RQ9]
        r_d.cs      = 1'b1;
        r_d.oe_n    = 1'b1;
        r_d.we_n    = 1'b0;
        r_d.lanes_n = ~r_q.lanes; // [RQ16]
        r_d.drive   = 1'b1;
        // write strobe is the ending edge; all others held [RQ5] [RQ6]
        if (r_q.cnt == `ASBC_CNT_ZERO)
        begin
          r_d.we_n = 1'b1;
          r_d.st   = ST_WEND;
        end
      end
      ST_WEND:
      begin
        // strobe high first, then deselect a cycle later [RQ8]
        r_d.cs      = 1'b0;
        r_d.lanes_n = 2'b11;
        r_d.drive   = 1'b0;
        r_d.done    = 1'b1;
        r_d.st      = ST_IDLE;
      end
      ST_TURN:
      begin
        // wait memory float time before next access [RQ7]
        if (r_q.cnt == `ASBC_CNT_ZERO)
        begin
          r_d.st = ST_IDLE;
        end
      end
      default:
      begin
        r_d.st = ST_IDLE;
      end
    endcase
    if (!ce_i)
    begin
      r_d = r_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      r_q         <= '0;
      r_q.st      <= ST_IDLE;
      r_q.we_n    <= 1'b1;
      r_q.oe_n    <= 1'b1;
      r_q.lanes_n <= 2'b11;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign req_ready_o        = (r_q.st == ST_IDLE) && ce_i;
  // pulse counts only in an enabled cycle, so a freeze cannot repeat it
  assign rsp_valid_o        = r_q.done && ce_i;
  assign rsp_rdata_o        = r_q.rdata;
  assign mem_addr_o         = r_q.addr;
  assign chip_select_n_o    = ~r_q.cs;
  assign chip_select_hi_o   = r_q.cs;
  assign write_n_o          = r_q.we_n;
  assign out_drive_n_o      = r_q.oe_n;
  assign upper_byte_sel_n_o = r_q.lanes_n[1];
  assign lower_byte_sel_n_o = r_q.lanes_n[0];
  assign mem_data_o         = r_q.wdata;
  // data held from write start, well beyond setup [RQ17]
  assign mem_data_oe_n_o    = {`ASBC_DATA_W{~r_q.drive}};

  sequence s_wr_start;
    $fell(r_q.we_n);
  endsequence

  sequence s_wr_end;
    $rose(r_q.we_n) && r_q.cs;
  endsequence

  a_data_setup: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RQ17]
    s_wr_end |-> $past(r_q.drive, SD_CYC))
    else $error("write data not set up before write end");

  a_read_no_write: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RQ10]
    (r_q.st == ST_READ) |-> r_q.we_n)
    else $error("write strobe low in read");
  a_no_contention: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RQ7]
    r_q.drive |-> r_q.oe_n)
    else $error("bus driven while memory may drive");
  a_write_len: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RQ15]
    s_wr_start |-> !r_q.we_n [*4])
    else $error("write pulse too short");
  a_select_float: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RQ8]
    $fell(r_q.cs) |-> r_q.we_n)
    else $error("deselect while write strobe low");
  a_lanes_held: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RQ16]
    (!r_q.we_n && !$past(r_q.we_n) && ce_i) |-> $stable(r_q.lanes_n))
    else $error("byte selects moved during write");
  a_addr_held: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RQ11]
    r_q.cs |-> $stable(r_q.addr))
    else $error("address moved while selected");
  a_wr_overlap: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RQ5]
    !r_q.we_n |-> (r_q.cs && r_q.lanes_n != 2'b11))
    else $error("write strobe without selects");
  a_idle_float: assert property (@(posedge clk_i) disable iff (!rst_b_i) // [RQ1]
    (r_q.st == ST_IDLE) |-> !r_q.drive)
    else $error("bus driven in idle");
endmodule
`default_nettype wire

// [core/asbc_regs.svh]
// timing constants for the async sram host controller
// assumes a 100 MHz clock; ns figures per speed grade
`ifndef ASBC_REGS_SVH
`define ASBC_REGS_SVH
`define ASBC_CLK_NS         10
`define ASBC_AA_FAST_NS     55
`define ASBC_AA_SLOW_NS     70
`define ASBC_AW_FAST_NS     40
`define ASBC_AW_SLOW_NS     60
`define ASBC_PWE_FAST_NS    40
`define ASBC_PWE_SLOW_NS    45
`define ASBC_SD_FAST_NS     25
`define ASBC_SD_SLOW_NS     30
`define ASBC_HZ_FAST_NS     20
`define ASBC_HZ_SLOW_NS     25
`define ASBC_CYC(ns)        (((ns) + `ASBC_CLK_NS - 1) / `ASBC_CLK_NS)
`define ASBC_ADDR_W         20
`define ASBC_DATA_W         16
`define ASBC_CNT_W          4
`define ASBC_CNT_ZERO       4'h0
`define ASBC_CNT_ONE        4'h1
`endif

// [core/asbc_pkg.sv]
// types for the async sram host controller
// assumes asbc_regs.svh is on the include path
`include "asbc_regs.svh"
package asbc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_WEND,
    ST_TURN
  } asbc_state_t;

  typedef struct packed {
    asbc_state_t                  st;
    logic [`ASBC_CNT_W-1:0]       cnt;
    logic [`ASBC_ADDR_W-1:0]      addr;
    logic [`ASBC_DATA_W-1:0]      wdata;
    logic [`ASBC_DATA_W-1:0]      rdata;
    logic [1:0]                   lanes_n;
    logic [1:0]                   lanes;
    logic                         cs;
    logic                         we_n;
    logic                         oe_n;
    logic                         drive;
    logic                         done;
    logic [`ASBC_DATA_W-1:0]      s1;
    logic [`ASBC_DATA_W-1:0]      s2;
    logic [`ASBC_DATA_W-1:0]      s3;
  } asbc_reg_t;
endpackage

// [tb/asbc_mem_model.sv]
// behavioural model of the 16-bit asynchronous static memory, 16 words
// assumes the bench clock to time its access delay and to store writes
`timescale 1ns/100ps
`default_nettype none
module asbc_mem_model
#(
  parameter int ACC_CYC = 6
)
(
  input  wire logic        clk_i,
  input  wire logic [19:0] addr_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        chip_select_hi_i,
  input  wire logic        write_n_i,
  input  wire logic        out_drive_n_i,
  input  wire logic        upper_byte_sel_n_i,
  input  wire logic        lower_byte_sel_n_i,
  input  wire logic [15:0] dq_i,
  output logic      [15:0] dq_o,
  output logic      [15:0] dq_en_o
);
  logic [15:0] mem [0:15];
  logic [15:0] pat = 16'h0;
  logic [3:0]  acc = 4'h0;
  logic [24:0] key_q = 25'h0;
  logic        sel;
  logic        rd;
  logic [24:0] key;
  assign sel = !chip_select_n_i && chip_select_hi_i
               && !(upper_byte_sel_n_i && lower_byte_sel_n_i);
  assign rd = sel && write_n_i && !out_drive_n_i;
  assign dq_en_o = {{8{rd && !upper_byte_sel_n_i}}, {8{rd && !lower_byte_sel_n_i}}};
  assign key = {addr_i, out_drive_n_i, upper_byte_sel_n_i, lower_byte_sel_n_i, sel, write_n_i};
  // garbage until the access time has run out
  assign dq_o = (acc >= ACC_CYC - 1) ? mem[addr_i[3:0]] : pat;
  always @(posedge clk_i)
  begin
    pat <= pat + 16'h9e37;
    key_q <= key;
    acc <= (key != key_q) ? 4'h0 : ((acc == 4'hf) ? acc : acc + 4'h1);
    if (sel && !write_n_i)
    begin
      if (!lower_byte_sel_n_i) mem[addr_i[3:0]][7:0] <= dq_i[7:0];
      if (!upper_byte_sel_n_i) mem[addr_i[3:0]][15:8] <= dq_i[15:8];
    end
  end
endmodule
`default_nettype wire

// [tb/asbc_ctrl_tb.sv]
// self-checking bench: random lane writes and reads against a shadow
// assumes asbc_regs.svh on the include path; fast grade memory model
`timescale 1ns/100ps
`include "asbc_regs.svh"
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end
module asbc_ctrl_tb;
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        req_valid_i = 1'b0;
  logic        req_write_i = 1'b0;
  logic [19:0] req_addr_i = 20'h0;
  logic [15:0] req_wdata_i = 16'h0;
  logic [1:0]  req_lanes_i = 2'h0;
  logic        req_ready_o, rsp_valid_o, cs_n, cs_hi, we_n, oe_n, ub_n, lb_n;
  logic [15:0] rsp_rdata_o, mem_data_o, oe_b, dev_q, dev_en, dq, sh [0:15];
  logic [19:0] mem_addr_o;
  logic [15:0] eq [$];
  logic [15:0] mq [$];
  logic [31:0] rs = 32'd75;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cyc = 0;
  logic        ce_i = 1'b1;
  logic [31:0] rc = 32'd75;
  logic [15:0] ld = 16'h0;
  logic [15:0] lm = 16'hffff;
  logic [15:0] ed;
  logic [15:0] em;
  // undriven pins show a changing pattern
  assign dq = (~oe_b & mem_data_o) | (oe_b & dev_en & dev_q) | (oe_b & ~dev_en & cyc[15:0]);
  asbc_ctrl dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .req_valid_i(req_valid_i),
    .req_write_i(req_write_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_lanes_i(req_lanes_i), .req_ready_o(req_ready_o), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .mem_addr_o(mem_addr_o), .chip_select_n_o(cs_n),
    .chip_select_hi_o(cs_hi), .write_n_o(we_n), .out_drive_n_o(oe_n),
    .upper_byte_sel_n_o(ub_n), .lower_byte_sel_n_o(lb_n), .mem_data_i(dq),
    .mem_data_o(mem_data_o), .mem_data_oe_n_o(oe_b));
  asbc_mem_model mem (.clk_i(clk_i), .addr_i(mem_addr_o), .chip_select_n_i(cs_n),
    .chip_select_hi_i(cs_hi), .write_n_i(we_n), .out_drive_n_i(oe_n),
    .upper_byte_sel_n_i(ub_n), .lower_byte_sel_n_i(lb_n), .dq_i(dq), .dq_o(dev_q),
    .dq_en_o(dev_en));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic close_out();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic op(input logic w, input logic [3:0] a, input logic [15:0] d,
                    input logic [1:0] l);
    logic [15:0] m;
    m = {{8{l[1]}}, {8{l[0]}}};
    @(posedge clk_i);
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_addr_i <= {16'h0, a};
    req_wdata_i <= d;
    req_lanes_i <= l;
    @(negedge clk_i);
    while (req_ready_o !== 1'b1) @(negedge clk_i);
    // a write answer leaves the last read data standing
    if (w)
    begin
      sh[a] = (sh[a] & ~m) | (d & m);
    end
    else
    begin
      ld = sh[a];
      lm = m;
    end
    eq.push_back(ld);
    mq.push_back(lm);
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    while (eq.size() != 0) @(posedge clk_i);
  endtask
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc++;
    // random clock-enable gaps
    rc <= xs(rc);
    ce_i <= (rc[1:0] != 2'b00);
    if (cyc == 6000)
    begin
      miscompares++;
      close_out();
    end
  end
  always @(negedge clk_i)
  begin
    `CHK(~oe_b & dev_en, 16'h0)
    if (rsp_valid_o === 1'b1)
    begin
      if (eq.size() == 0)
        `CHK(rsp_valid_o, 1'b0)
      else
      begin
        em = mq.pop_front();
        ed = eq.pop_front();
        `CHK(rsp_rdata_o & em, ed & em)
      end
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    // a request with no lane is refused: memory stays deselected
    req_valid_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    req_valid_i <= 1'b0;
    @(negedge clk_i);
    `CHK({cs_n, cs_hi}, 2'b10)
    for (int i = 0; i < 16; i++)
    begin
      rs = xs(rs);
      op(1'b1, i[3:0], rs[15:0], 2'b11);
    end
    for (int i = 0; i < 60; i++)
    begin
      rs = xs(rs);
      op(rs[0], rs[7:4], rs[31:16], (rs[9:8] == 2'b00) ? 2'b11 : rs[9:8]);
    end
    for (int i = 0; i < 16; i++)
      op(1'b0, i[3:0], 16'h0, 2'b11);
    close_out();
  end
endmodule
`default_nettype wire
